//--- hw/spdp_defines.vh
// constants for the serial program/debug port
`ifndef SPDP_DEFINES_VH
`define SPDP_DEFINES_VH
`define SPDP_NPAIRS        3
`define SPDP_PSEL_W        2
`define SPDP_CMD_W         4
`define SPDP_WORD_W        24
`define SPDP_CNT_W         5
`define SPDP_KEY_W         32
`define SPDP_KEY_VAL       32'h5A5AC3C3
`define SPDP_EXEC_LO       24'h800000
`define SPDP_EXEC_HI       24'h8007FF
// 4-bit command codes
`define SPDP_CMD_EXEC      4'h0
`define SPDP_CMD_READ      4'h1
`define SPDP_CMD_EXEC_MODE 4'h2
`define SPDP_CMD_DBG_MODE  4'h3
`define SPDP_CMD_PE        4'h4
// main state machine codes
`define SPDP_ST_IDLE       3'h0
`define SPDP_ST_KEY        3'h1
`define SPDP_ST_CMD        3'h2
`define SPDP_ST_PAY        3'h3
`define SPDP_ST_TURN       3'h4
`define SPDP_ST_OUT        3'h5
`endif

//--- hw/spdp_sync.v
// two-flop synchroniser with edge detection on the second stage
`timescale 1ns/1ps
`default_nettype none
module spdp_sync (
  // clock and reset
  input  wire i_clk,
  input  wire i_rstn,
  // asynchronous input
  input  wire i_async,
  // synchronised level and edges
  output reg  o_level,
  output wire o_rise,
  output wire o_fall
);
  reg meta_q;
  reg prev_q;
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      meta_q  <= 1'b0;
      o_level <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      meta_q  <= i_async;
      o_level <= meta_q;
      prev_q  <= o_level;
    end
  end
  assign o_rise = o_level & ~prev_q;
  assign o_fall = ~o_level & prev_q;
endmodule
`default_nettype wire

//--- hw/spdp_top.v
// serial program/debug port: mode entry, 4-bit commands, payload and query readback
// Behaviour
// (RQ1) The data line is two-way: it takes data and instructions in and drives answers out.
// (RQ2) The programmer's clock paces the link and data is sampled only on its rising edge.
// (RQ3) Every numbered clock/data pair works the same for programming.
// (RQ4) The programmer uses clock and data of one pair only, never mixed pairs.
// (RQ5) Control uses 4-bit commands plus processor instructions passed over the link.
// (RQ6) The programmer enters or leaves the mode with master clear and a clocked key.
// (RQ7) On a query the device drives the requested data back on the data line.
// (RQ8) The clock-train count tells commands, control commands and payload apart.
// (RQ9) An internal state machine runs each step; the programmer orders the steps.
// (RQ10) Executive memory 800000h-8007FFh runs code but is hidden from user mode.
// (RQ11) Only the pair chosen by the debug port select bits serves the debugger.
// (RQ12) Debugging is off while executive-based programming is in use.
// (RQ13) The programmer loads the executive with basic commands before using it.
// (RQ14) A loaded executive takes its own commands to erase, program and verify.
// (RQ15) The data line stays an input except while query data is returned.
`timescale 1ns/1ps
`default_nettype none
`include "spdp_defines.vh"
module spdp_top (
  // clock and reset
  input  wire                      I_CLK_SYS,
  input  wire                      I_RSTN,
  // numbered pin pairs and master clear
  input  wire [`SPDP_NPAIRS-1:0]   I_PCLK,
  input  wire [`SPDP_NPAIRS-1:0]   I_PDAT_IN,
  output reg  [`SPDP_NPAIRS-1:0]   O_PDAT_OUT,
  output reg  [`SPDP_NPAIRS-1:0]   O_PDAT_OE,
  input  wire                      I_MASTER_CLEAR_PIN_N,
  // configuration
  input  wire [`SPDP_PSEL_W-1:0]   I_DBG_PORT_SEL,
  input  wire                      I_USER_MODE,
  // core side: instruction/payload out, query data in
  output reg  [`SPDP_WORD_W-1:0]   O_INSTR,
  output reg                       O_INSTR_VLD,
  output reg  [`SPDP_CMD_W-1:0]    O_CMD,
  input  wire [`SPDP_WORD_W-1:0]   I_RD_DATA,
  // exec memory guard
  input  wire [`SPDP_WORD_W-1:0]   I_FETCH_ADDR,
  output reg                       O_EXEC_ALLOW,
  // status
  output reg                       O_PROG_MODE,
  output reg                       O_EXEC_MODE,
  output reg                       O_DBG_EN,
  output reg  [`SPDP_PSEL_W-1:0]   O_ACTIVE_PAIR
);
  wire [`SPDP_NPAIRS-1:0] clk_r, clk_f, dat_s;
  wire                    master_clear_pin_s;
  genvar g;
  generate
    for (g = 0; g < `SPDP_NPAIRS; g = g + 1) begin : g_pair
      spdp_sync u_c (.i_clk(I_CLK_SYS), .i_rstn(I_RSTN), .i_async(I_PCLK[g]),
                     .o_level(), .o_rise(clk_r[g]), .o_fall(clk_f[g]));
      spdp_sync u_d (.i_clk(I_CLK_SYS), .i_rstn(I_RSTN), .i_async(I_PDAT_IN[g]),
                     .o_level(dat_s[g]), .o_rise(), .o_fall());
    end
  endgenerate
  spdp_sync u_m (.i_clk(I_CLK_SYS), .i_rstn(I_RSTN), .i_async(I_MASTER_CLEAR_PIN_N),
                 .o_level(master_clear_pin_s), .o_rise(), .o_fall());

  function in_exec;
    input [`SPDP_WORD_W-1:0] a;
    begin
      in_exec = (a >= `SPDP_EXEC_LO) && (a <= `SPDP_EXEC_HI);
    end
  endfunction

  reg [2:0]                 st_q;
  reg [`SPDP_PSEL_W-1:0]    pair_q;
  reg [`SPDP_CNT_W-1:0]     cnt_q;
  reg [`SPDP_KEY_W-1:0]     key_q;
  reg [`SPDP_WORD_W-1:0]    sh_q;
  reg [`SPDP_CMD_W-1:0]     cmd_q;
  reg                       exec_q;
  reg                       drive_q;

  // pair chosen at key time follows the programmer; any pair may start entry
  wire clk_rise = clk_r[pair_q];                                        // see (RQ4)
  wire clk_fall = clk_f[pair_q];
  wire din      = dat_s[pair_q];
  wire any_rise = |clk_r;

  reg [`SPDP_PSEL_W-1:0] first_pair;
  integer k;
  always @* begin
    first_pair = {`SPDP_PSEL_W{1'b0}};
    for (k = `SPDP_NPAIRS - 1; k >= 0; k = k - 1) begin
      if (clk_r[k]) begin
        first_pair = k[`SPDP_PSEL_W-1:0];                               // see (RQ3)
      end
    end
  end

  always @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      st_q        <= `SPDP_ST_IDLE;
      pair_q      <= {`SPDP_PSEL_W{1'b0}};
      cnt_q       <= {`SPDP_CNT_W{1'b0}};
      key_q       <= {`SPDP_KEY_W{1'b0}};
      sh_q        <= {`SPDP_WORD_W{1'b0}};
      cmd_q       <= {`SPDP_CMD_W{1'b0}};
      exec_q      <= 1'b0;
      drive_q     <= 1'b0;
      O_INSTR     <= {`SPDP_WORD_W{1'b0}};
      O_INSTR_VLD <= 1'b0;
      O_CMD       <= {`SPDP_CMD_W{1'b0}};
      O_PROG_MODE <= 1'b0;
    end else begin
      O_INSTR_VLD <= 1'b0;
      // master clear released leaves the mode at any step
      if (master_clear_pin_s && st_q != `SPDP_ST_IDLE && st_q != `SPDP_ST_KEY) begin  // see (RQ6)
        st_q        <= `SPDP_ST_IDLE;
        O_PROG_MODE <= 1'b0;
        // a stale key would let part of the next entry sequence match early
        key_q       <= {`SPDP_KEY_W{1'b0}};
        exec_q      <= 1'b0;
        drive_q     <= 1'b0;
      end else begin
        case (st_q)
          `SPDP_ST_IDLE: begin
            if (!master_clear_pin_s && any_rise) begin
              pair_q <= first_pair;
              key_q  <= {key_q[`SPDP_KEY_W-2:0], dat_s[first_pair]};
              st_q   <= `SPDP_ST_KEY;
            end
          end
          `SPDP_ST_KEY: begin
            if (master_clear_pin_s) begin
              st_q  <= `SPDP_ST_IDLE;
              key_q <= {`SPDP_KEY_W{1'b0}};
            end else if (key_q == `SPDP_KEY_VAL) begin
              O_PROG_MODE <= 1'b1;
              cnt_q       <= {`SPDP_CNT_W{1'b0}};
              st_q        <= `SPDP_ST_CMD;
            end else if (clk_rise) begin                                // see (RQ2)
              key_q <= {key_q[`SPDP_KEY_W-2:0], din};
            end
          end
          `SPDP_ST_CMD: begin
            // four clocks carry the command code, lsb first
            if (clk_rise) begin                                         // see (RQ8)
              cmd_q <= {din, cmd_q[`SPDP_CMD_W-1:1]};
              cnt_q <= cnt_q + 1'b1;
              if (cnt_q == `SPDP_CMD_W - 1) begin
                cnt_q <= {`SPDP_CNT_W{1'b0}};
                O_CMD <= {din, cmd_q[`SPDP_CMD_W-1:1]};
                st_q  <= ({din, cmd_q[`SPDP_CMD_W-1:1]} == `SPDP_CMD_READ)
                         ? `SPDP_ST_TURN : `SPDP_ST_PAY;                // see (RQ9)
                if ({din, cmd_q[`SPDP_CMD_W-1:1]} == `SPDP_CMD_READ)
                  sh_q <= I_RD_DATA;
              end
            end
          end
          `SPDP_ST_PAY: begin
            // a 24-clock train is payload: an instruction or executive command word
            if (clk_rise) begin                                         // see (RQ1)
              sh_q  <= {din, sh_q[`SPDP_WORD_W-1:1]};
              cnt_q <= cnt_q + 1'b1;
              if (cnt_q == `SPDP_WORD_W - 1) begin
                cnt_q       <= {`SPDP_CNT_W{1'b0}};
                O_INSTR     <= {din, sh_q[`SPDP_WORD_W-1:1]};
                O_INSTR_VLD <= 1'b1;                                    // see (RQ5)
                if (cmd_q == `SPDP_CMD_EXEC_MODE)
                  exec_q <= 1'b1;                                       // see (RQ14)
                else if (cmd_q == `SPDP_CMD_DBG_MODE)
                  exec_q <= 1'b0;
                st_q <= `SPDP_ST_CMD;
              end
            end
          end
          `SPDP_ST_TURN: begin
            // first falling edge hands the line over, so no contention
            if (clk_fall) begin                                         // see (RQ15)
              drive_q <= 1'b1;
              st_q    <= `SPDP_ST_OUT;
            end
          end
          `SPDP_ST_OUT: begin
            // new bit on each falling edge, programmer samples on rising
            if (clk_fall) begin                                         // see (RQ7)
              if (cnt_q == `SPDP_WORD_W - 1) begin
                cnt_q   <= {`SPDP_CNT_W{1'b0}};
                drive_q <= 1'b0;
                st_q    <= `SPDP_ST_CMD;
              end else begin
                sh_q  <= {1'b0, sh_q[`SPDP_WORD_W-1:1]};
                cnt_q <= cnt_q + 1'b1;
              end
            end
          end
          default: st_q <= `SPDP_ST_IDLE;
        endcase
      end
    end
  end

  // pin drivers, debug gating and executive guard
  always @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      O_PDAT_OUT    <= {`SPDP_NPAIRS{1'b0}};
      O_PDAT_OE     <= {`SPDP_NPAIRS{1'b0}};
      O_EXEC_MODE   <= 1'b0;
      O_DBG_EN      <= 1'b0;
      O_ACTIVE_PAIR <= {`SPDP_PSEL_W{1'b0}};
      O_EXEC_ALLOW  <= 1'b0;
    end else begin
      O_PDAT_OUT    <= {`SPDP_NPAIRS{sh_q[0]}};
      // release at once when master clear ends the mode, so the drive never outlives it
      O_PDAT_OE     <= (drive_q && !master_clear_pin_s) ? ({{(`SPDP_NPAIRS-1){1'b0}}, 1'b1} << pair_q)
                                            : {`SPDP_NPAIRS{1'b0}};     // see (RQ15)
      O_EXEC_MODE   <= exec_q;
      // debugger only on the configured pair, never in executive mode
      O_DBG_EN      <= O_PROG_MODE && !exec_q
                       && (pair_q == I_DBG_PORT_SEL);                   // see (RQ11) (RQ12)
      O_ACTIVE_PAIR <= pair_q;
      O_EXEC_ALLOW  <= in_exec(I_FETCH_ADDR) && !I_USER_MODE;           // see (RQ10)
    end
  end
endmodule
`default_nettype wire

//--- verif/serial_program_debug_port_bench.sv
// self-checking bench for the serial program/debug port
`timescale 1ns/1ps
`default_nettype none
`include "spdp_defines.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module serial_program_debug_port_bench;
  logic clk = 1'b0, rstn = 1'b0, user = 1'b0, exec = 1'b0;
  logic [1:0] sel = '0;
  logic [23:0] rd = '0, fa = '0, w;
  logic [2:0] pclk, pdat, oe, dout, pin;
  logic master_clear_pin_n, vld, allow, pm, em, dbg;
  logic [23:0] instr, exp_w;
  logic [3:0] cmd;
  logic [1:0] apair;
  int err_count = 0, n_compared = 0, cyc = 0, c;
  logic [23:0] exp_q[$];
  int cl[7] = '{0, 2, 4, 3, 1, 1, 0}; // load, enter and use the executive
  logic [23:0] at[4] = '{24'h7FFFFF, 24'h800000, 24'h8007FF, 24'h800800};
  assign pin = (oe & dout) | (~oe & pdat);
  always #12.5 clk = ~clk;
  spdp_prog P (.o_pclk(pclk), .o_pdat(pdat), .o_master_clear_pin_n(master_clear_pin_n), .i_pdat(pin));
  spdp_top DUT (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_PCLK(pclk), .I_PDAT_IN(pin),
    .O_PDAT_OUT(dout), .O_PDAT_OE(oe), .I_MASTER_CLEAR_PIN_N(master_clear_pin_n), .I_DBG_PORT_SEL(sel),
    .I_USER_MODE(user), .O_INSTR(instr), .O_INSTR_VLD(vld), .O_CMD(cmd), .I_RD_DATA(rd),
    .I_FETCH_ADDR(fa), .O_EXEC_ALLOW(allow), .O_PROG_MODE(pm), .O_EXEC_MODE(em),
    .O_DBG_EN(dbg), .O_ACTIVE_PAIR(apair));
  task complete_run;
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run;
    end
  end
  // each word strobe must match the oldest word sent
  always @(negedge clk) if (vld === 1'b1) begin
    `CHK(exp_q.size() > 0, 1'b1)
    if (exp_q.size() > 0) begin
      exp_w = exp_q.pop_front();
      `CHK(instr, exp_w)
    end
  end
  initial begin
    void'($urandom(32'hA370CA14));
    repeat (5) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    `CHK({pm, dbg, oe}, 5'h00)
    sel = 2'($urandom_range(2));
    P.pair = $urandom_range(2);
    repeat (4) @(negedge clk);
    P.o_master_clear_pin_n = 1'b0;
    P.send(`SPDP_KEY_VAL, 32, 1'b1);
    repeat (10) @(negedge clk);
    `CHK({pm, apair}, {1'b1, 2'(P.pair)})
    `CHK(dbg, 1'(P.pair == sel))
    // debug pair matches from here on, so the executive gate can be seen to act
    @(negedge clk) sel = 2'(P.pair);
    foreach (cl[i]) begin
      c = cl[i];
      @(negedge clk) rd = 24'($urandom);
      w = 24'($urandom);
      P.send(32'(c), 4, 1'b0);
      if (c == 1) begin
        P.read24(w);
        `CHK(w, rd)
      end else begin
        exp_q.push_back(w);
        P.send({8'h00, w}, 24, 1'b0);
        exec = (c == 2) ? 1'b1 : (c == 3) ? 1'b0 : exec;
      end
      repeat (10) @(negedge clk);
      `CHK({cmd, em, oe}, {4'(c), exec, 3'h0})
      `CHK(dbg, !exec && P.pair == sel)
    end
    for (int i = 0; i < 8; i++) begin
      @(negedge clk) fa = at[i>>1];
      user = 1'(i);
      @(negedge clk) `CHK(allow, (i > 1 && i < 6) && !user)
    end
    P.o_master_clear_pin_n = 1'b1;
    repeat (10) @(negedge clk);
    `CHK({pm, exp_q.size() == 0}, 2'b01)
    complete_run;
  end
endmodule
`default_nettype wire

//--- verif/spdp_prog.sv
// programmer model driving one numbered clock/data pair
`timescale 1ns/1ps
`default_nettype none
`include "spdp_defines.vh"
module spdp_prog (
  // pins
  output var logic [`SPDP_NPAIRS-1:0] o_pclk,
  output var logic [`SPDP_NPAIRS-1:0] o_pdat,
  output var logic                    o_master_clear_pin_n,
  input  wire logic [`SPDP_NPAIRS-1:0] i_pdat
);
  int pair = 0;
  initial begin
    o_pclk = '0;
    o_pdat = '0;
    o_master_clear_pin_n = 1'b1;
  end
  // clock stands low between bits; 200 ns per bit
  task automatic bit_io(input logic d, output logic q);
    o_pdat[pair] = d;
    #100 o_pclk[pair] = 1'b1;
    #90 q = i_pdat[pair];
    #10 o_pclk[pair] = 1'b0;
  endtask
  task automatic send(input logic [31:0] v, input int n, input bit msb);
    logic q;
    for (int i = 0; i < n; i++) bit_io(msb ? v[n-1-i] : v[i], q);
  endtask
  // released line toggles so a stale level never reads as data
  task automatic read24(output logic [23:0] w);
    for (int i = 0; i < 24; i++) bit_io(~o_pdat[pair], w[i]);
  endtask
endmodule
`default_nettype wire

//--- verif/spdp_props.sv
// assertion checker for the serial program/debug port
`timescale 1ns/1ps
`default_nettype none
`include "spdp_defines.vh"
module spdp_props (
  // clock, reset and inputs
  input wire logic                     I_CLK_SYS,
  input wire logic                     I_RSTN,
  input wire logic                     I_MASTER_CLEAR_PIN_N,
  input wire logic [`SPDP_PSEL_W-1:0]  I_DBG_PORT_SEL,
  input wire logic                     I_USER_MODE,
  input wire logic [`SPDP_WORD_W-1:0]  I_FETCH_ADDR,
  // outputs watched
  input wire logic [`SPDP_NPAIRS-1:0]  O_PDAT_OE,
  input wire logic                     O_INSTR_VLD,
  input wire logic                     O_EXEC_ALLOW,
  input wire logic                     O_PROG_MODE,
  input wire logic                     O_EXEC_MODE,
  input wire logic                     O_DBG_EN,
  input wire logic [`SPDP_PSEL_W-1:0]  O_ACTIVE_PAIR
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);
  sequence s_pulse; O_INSTR_VLD ##1 !O_INSTR_VLD; endsequence
  sequence s_drive; (|O_PDAT_OE) [*8]; endsequence
  sequence s_master_clear_pin_off; I_MASTER_CLEAR_PIN_N [*6]; endsequence
  property p_oe_pair; |O_PDAT_OE |-> O_PROG_MODE && O_PDAT_OE == (3'h1 << O_ACTIVE_PAIR); endproperty
  property p_oe_hold; $rose(|O_PDAT_OE) |-> s_drive; endproperty
  property p_exec; I_RSTN |=> O_EXEC_ALLOW == ($past(I_FETCH_ADDR) >= `SPDP_EXEC_LO &&
    $past(I_FETCH_ADDR) <= `SPDP_EXEC_HI && !$past(I_USER_MODE)); endproperty
  property p_dbg_exec; O_EXEC_MODE && $past(O_EXEC_MODE) |-> !O_DBG_EN; endproperty
  property p_dbg_pair; O_DBG_EN |-> O_ACTIVE_PAIR == $past(I_DBG_PORT_SEL); endproperty
  property p_vld_pulse; O_INSTR_VLD |-> s_pulse; endproperty
  property p_vld_mode; O_INSTR_VLD |-> O_PROG_MODE; endproperty
  property p_master_clear_pin; s_master_clear_pin_off |-> !O_PROG_MODE; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("drive off the active pair");
  a_oe_hold: assert property (p_oe_hold) else $error("readback drive cut short");
  a_exec: assert property (p_exec) else $error("executive fetch guard wrong");
  a_dbg_exec: assert property (p_dbg_exec) else $error("debug on in executive mode");
  a_dbg_pair: assert property (p_dbg_pair) else $error("debug pair not selected one");
  a_vld_pulse: assert property (p_vld_pulse) else $error("word strobe too long");
  a_vld_mode: assert property (p_vld_mode) else $error("word outside prog mode");
  a_master_clear_pin: assert property (p_master_clear_pin) else $error("mode kept with clear high");
endmodule
bind spdp_top spdp_props u_props (.I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_MASTER_CLEAR_PIN_N(I_MASTER_CLEAR_PIN_N),
  .I_DBG_PORT_SEL(I_DBG_PORT_SEL), .I_USER_MODE(I_USER_MODE), .I_FETCH_ADDR(I_FETCH_ADDR),
  .O_PDAT_OE(O_PDAT_OE), .O_INSTR_VLD(O_INSTR_VLD), .O_EXEC_ALLOW(O_EXEC_ALLOW),
  .O_PROG_MODE(O_PROG_MODE), .O_EXEC_MODE(O_EXEC_MODE), .O_DBG_EN(O_DBG_EN),
  .O_ACTIVE_PAIR(O_ACTIVE_PAIR));
`default_nettype wire
